// File: verilog/flag_host_pkg.sv
// Package with constants and carrier types for the semaphore flag host controller.
package flag_host_pkg;
    localparam int CLK_MHZ          = 250;
    localparam int ADDR_W           = 14;
    localparam int DATA_W           = 16;
    localparam int FLAG_COUNT       = 8;
    localparam int IDX_W            = 3;
    localparam int BIT_ZERO_POS     = 0;
    localparam int ACCESS_NS        = 60;
    localparam int GAP_NS           = 20;
    localparam int ACCESS_CYC       = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC          = (GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W            = 8;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

    typedef enum logic [1:0] {
        OP_CLAIM   = 2'h0,
        OP_RELEASE = 2'h1,
        OP_POLL    = 2'h2,
        OP_WITHDRAW = 2'h3
    } op_t;

    typedef struct packed {
        op_t              op;
        logic [IDX_W-1:0] idx;
    } cmd_t;

    typedef struct packed {
        logic              done;
        logic              owned;
        logic [IDX_W-1:0]  idx;
    } rsp_t;

    typedef struct packed {
        logic              chip_en_n;
        logic              flag_space_select_n;
        logic              rd_wr_n;
        logic              out_en_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              data_oe;
    } pins_t;
endpackage

// File: verilog/flag_pulse_timer.sv
// Cycle counter that marks the end of one pin phase with a one-cycle pulse.
`timescale 1ns/1ns
module flag_pulse_timer (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        start,
    input  wire logic [flag_host_pkg::CNT_W-1:0] len,
    output logic                             expired
);
    import flag_host_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic             run_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (start) begin
            cnt_q <= len;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q <= 8'h01) begin
                run_q <= 1'b0;
            end
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // Start is left out here, since callers derive start from expired in the same cycle.
    assign expired = run_q && (cnt_q <= 8'h01);
endmodule

// File: verilog/flag_host.sv
// Host controller that claims, polls and releases semaphore flags over the port pins.
// Summary of operation
// - Flag access only with flag select low.
// - Deassert select or enable between polling reads.
// - Claim is write zero, then read back.
// - After failure, poll again or write one.
// - Memory enable high while flag select low.
// - Write one to every flag at start-up.
`timescale 1ns/1ns
module flag_host (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire flag_host_pkg::cmd_t    cmd,
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    output flag_host_pkg::rsp_t         rsp,
    output flag_host_pkg::pins_t        pins,
    input  wire logic [flag_host_pkg::DATA_W-1:0] rdata,
    output logic                        init_done
);
    import flag_host_pkg::*;

    typedef enum logic [2:0] {
        ST_INIT_WR = 3'h0,
        ST_IDLE    = 3'h1,
        ST_WRITE   = 3'h2,
        ST_GAP     = 3'h3,
        ST_READ    = 3'h4,
        ST_DONE    = 3'h5
    } state_t;

    state_t           state_q;
    cmd_t             cmd_q;
    logic [IDX_W-1:0] init_idx_q;
    logic             init_done_q;
    logic [DATA_W-1:0] s1_q;
    logic [DATA_W-1:0] s2_q;
    logic [DATA_W-1:0] s3_q;
    logic             owned_q;
    logic             done_q;
    pins_t            pins_q;
    logic             tstart;
    logic [CNT_W-1:0] tlen;
    logic             texp;

    // Value written for an operation; only data bit zero carries meaning.
    function automatic logic wr_bit(input op_t op);
        return (op == OP_RELEASE || op == OP_WITHDRAW);
    endfunction

    // Builds the pin image for a flag access with the memory enable held off.
    function automatic pins_t flag_pins(input logic [IDX_W-1:0] idx, input logic wr,
                                        input logic rd, input logic bitv);
        pins_t p;
        p = '0;
        p.chip_en_n           = 1'b1;
        p.flag_space_select_n = !(wr || rd);
        p.rd_wr_n             = !wr;
        p.out_en_n            = !rd;
        p.addr                = '0;
        p.addr[IDX_W-1:0]     = idx;
        p.wdata               = '0;
        p.wdata[BIT_ZERO_POS] = bitv;
        p.data_oe             = wr;
        return p;
    endfunction

    flag_pulse_timer u_timer (
        .clk     (clk),
        .srst    (srst),
        .start   (tstart),
        .len     (tlen),
        .expired (texp)
    );

    // Three-stage input capture; only stages two and three are compared.
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= rdata;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        tstart = 1'b0;
        tlen   = CNT_W'(ACCESS_CYC);
        case (state_q)
            ST_IDLE:    tstart = cmd_valid || !init_done_q;
            ST_INIT_WR: begin
                tstart = texp && (init_idx_q != IDX_LAST);
                tlen   = CNT_W'(GAP_CYC);
            end
            ST_WRITE:   begin
                tstart = texp && (cmd_q.op == OP_CLAIM);
                tlen   = CNT_W'(GAP_CYC);
            end
            ST_GAP:     tstart = texp;
            default:    tstart = 1'b0;
        endcase
    end

    // The command is held for the whole access so the pins stay stable.
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q <= '{op: OP_CLAIM, idx: '0};
        end else if (state_q == ST_IDLE && init_done_q && cmd_valid) begin
            cmd_q <= cmd;
        end
    end

    // Start-up walk over all flags; every reset begins it again at flag zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            init_idx_q  <= '0;
            init_done_q <= 1'b0;
        end else if (state_q == ST_INIT_WR && texp) begin
            if (init_idx_q == IDX_LAST) begin
                init_done_q <= 1'b1;
            end else begin
                init_idx_q <= init_idx_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (!init_done_q) begin
                        state_q <= ST_INIT_WR;
                    end else if (cmd_valid) begin
                        state_q <= (cmd.op == OP_POLL) ? ST_READ : ST_WRITE;
                    end
                end
                ST_INIT_WR: begin
                    if (texp) begin
                        state_q <= (init_idx_q == IDX_LAST) ? ST_IDLE : ST_GAP;
                    end
                end
                ST_WRITE: begin
                    if (texp) begin
                        // A claim must be read back after its write, never before.
                        state_q <= (cmd_q.op == OP_CLAIM) ? ST_GAP : ST_DONE;
                    end
                end
                ST_GAP: begin
                    // Select drops between accesses so the read latch reloads.
                    if (texp) begin
                        state_q <= init_done_q ? ST_READ : ST_INIT_WR;
                    end
                end
                ST_READ: begin
                    if (texp) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Read data passes three stages, so sampling waits out the access time.
    always_ff @(posedge clk) begin
        if (srst) begin
            owned_q <= 1'b0;
        end else if (state_q == ST_READ && texp) begin
            // Two agreeing stages with a zero on every bit mean this side holds the token.
            owned_q <= (s2_q == s3_q) && (s3_q == '0);
        end else if (state_q == ST_WRITE && texp && cmd_q.op != OP_CLAIM) begin
            owned_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_DONE);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pins_q <= flag_pins('0, 1'b0, 1'b0, 1'b0);
        end else begin
            case (state_q)
                ST_INIT_WR: pins_q <= flag_pins(init_idx_q, !texp, 1'b0, 1'b1);
                ST_WRITE:   pins_q <= flag_pins(cmd_q.idx, !texp, 1'b0, wr_bit(cmd_q.op));
                ST_READ:    pins_q <= flag_pins(cmd_q.idx, 1'b0, !texp, 1'b0);
                default:    pins_q <= flag_pins(cmd_q.idx, 1'b0, 1'b0, 1'b0);
            endcase
        end
    end

    // Flags are advisory; the host never gates other traffic on them.
    assign cmd_ready = (state_q == ST_IDLE) && init_done_q;
    assign init_done = init_done_q;
    assign pins      = pins_q;
    assign rsp       = '{done: done_q, owned: owned_q, idx: cmd_q.idx};
endmodule

// File: sim/flag_dev_model.sv
// Behavioural model of one device port with eight shared flags and a far-side hook.
`timescale 1ns/1ns
module flag_dev_model (
    input  wire logic                        clk,
    input  wire flag_host_pkg::pins_t        pins,
    input  wire logic                        o_we,
    input  wire logic [2:0]                  o_idx,
    input  wire logic                        o_val,
    output logic [flag_host_pkg::DATA_W-1:0] rdata,
    output logic [7:0]                       own_o
);
    import flag_host_pkg::*;
    // Power-up latches hold garbage on purpose, so only start-up writes can free them.
    logic [7:0]        hreq  = 8'hA5;
    logic [7:0]        oreq  = 8'h00;
    logic [7:0]        own_h = 8'h00;
    logic [7:0]        own_q = 8'h00;
    logic [2:0]        ix;
    logic              act;
    logic              rd;
    logic              rd_q  = 1'b0;
    logic [DATA_W-1:0] lat   = '0;
    assign ix = pins.addr[2:0];
    assign act = !pins.flag_space_select_n && pins.chip_en_n;
    assign rd = act && !pins.out_en_n;
    assign own_o = own_q;
    // Plain processes, so the power-up values above may stand beside the clocked writes.
    always @(posedge clk) begin
        if (act && !pins.rd_wr_n) begin
            hreq[ix] <= !pins.wdata[0];
        end
        if (o_we) begin
            oreq[o_idx] <= !o_val;
        end
    end
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!own_h[i] && !own_q[i]) begin
                own_h[i] <= hreq[i];
                own_q[i] <= oreq[i] && !hreq[i];
            end else if (own_h[i] && !hreq[i]) begin
                own_h[i] <= 1'b0;
                own_q[i] <= oreq[i];
            end else if (own_q[i] && !oreq[i]) begin
                own_q[i] <= 1'b0;
                own_h[i] <= hreq[i];
            end
        end
    end
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd && !rd_q) begin
            lat <= {DATA_W{!own_h[ix]}};
        end
    end
    // Outside a read the bus shows the inverse of the latch, never a stale match.
    assign rdata = rd_q ? lat : ~lat;
endmodule

// File: sim/flag_host_chk.sv
// Checker of the pin discipline of the flag host controller.
`timescale 1ns/1ns
module flag_host_chk (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire flag_host_pkg::cmd_t  cmd,
    input wire logic                 cmd_valid,
    input wire logic                 cmd_ready,
    input wire flag_host_pkg::pins_t pins,
    input wire logic                 init_done
);
    import flag_host_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic sel;
    logic wr;
    logic take;
    assign sel = !pins.flag_space_select_n;
    assign wr = sel && !pins.rd_wr_n;
    assign take = cmd_valid && cmd_ready;
    property p_mem_off; sel |-> pins.chip_en_n; endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory enable low in flag access");
    property p_rd_sel; (!pins.out_en_n || pins.data_oe) |-> sel; endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("access without flag select");
    property p_gap; (sel && !pins.out_en_n) |-> ##[1:20] (!sel || pins.out_en_n); endproperty
    a_gap: assert property (p_gap) else $error("read never ends");
    property p_claim;
        take && cmd.op == OP_CLAIM |-> ##[1:3] (wr && !pins.wdata[0]);
    endproperty
    a_claim: assert property (p_claim) else $error("claim does not write zero first");
    property p_free;
        take && (cmd.op == OP_RELEASE || cmd.op == OP_WITHDRAW) |-> ##[1:3] (wr && pins.wdata[0]);
    endproperty
    a_free: assert property (p_free) else $error("release does not write one");
    property p_init; $fell(srst) |-> ##[0:3] (wr && pins.wdata[0] && pins.addr[2:0] == 3'h0);
    endproperty
    a_init: assert property (p_init) else $error("start-up write missing");
    property p_rdy; cmd_ready |-> init_done; endproperty
    a_rdy: assert property (p_rdy) else $error("ready before start-up done");
    property p_init_end;
        $rose(init_done) |-> $past(wr && pins.wdata[0] && pins.addr[2:0] == 3'h7);
    endproperty
    a_init_end: assert property (p_init_end) else $error("start-up ends before last flag");
    c_claim: cover property (take && cmd.op == OP_CLAIM);
    c_wdraw: cover property (take && cmd.op == OP_WITHDRAW);
    c_poll: cover property (take && cmd.op == OP_POLL);
endmodule
bind flag_host flag_host_chk flag_host_chk_i (.clk(clk), .srst(srst), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .pins(pins), .init_done(init_done));

// File: sim/flag_host_tb.sv
// Self-checking bench for the flag host controller against a device model.
`timescale 1ns/1ns
module flag_host_tb;
    import flag_host_pkg::*;
    logic              clk       = 1'b0;
    logic              srst      = 1'b1;
    cmd_t              cmd       = '0;
    logic              cmd_valid = 1'b0;
    logic              o_we      = 1'b0;
    logic [2:0]        o_idx     = 3'h0;
    logic              o_val     = 1'b1;
    logic              cmd_ready;
    rsp_t              rsp;
    pins_t             pins;
    logic [DATA_W-1:0] rdata;
    logic              init_done;
    logic [7:0]        own_o;
    int                fail_count  = 0;
    int                comparisons = 0;
    always #2 clk = ~clk;
    flag_host flag_host_i (.clk(clk), .srst(srst), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp(rsp), .pins(pins), .rdata(rdata), .init_done(init_done));
    flag_dev_model flag_dev_model_i (.clk(clk), .pins(pins), .o_we(o_we), .o_idx(o_idx),
        .o_val(o_val), .rdata(rdata), .own_o(own_o));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic give_verdict;
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic run(input op_t op, input logic [2:0] idx, input logic exp);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        cmd.op = op;
        cmd.idx = idx;
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        n = 0;
        while (rsp.done !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        check({7'h0, rsp.done}, 8'h01);
        check({4'h0, rsp.owned, rsp.idx}, {4'h0, exp, idx});
    endtask
    // The far port writes one flag, standing in for the opposite processor.
    task automatic far(input logic [2:0] idx, input logic val);
        o_idx = idx;
        o_val = val;
        o_we = 1'b1;
        tick();
        o_we = 1'b0;
        tick();
    endtask
    task automatic do_reset;
        int n;
        srst = 1'b1;
        repeat (3) tick();
        srst = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        check({7'h0, init_done}, 8'h01);
    endtask
    task automatic t_all_flags;
        for (int i = 0; i < 8; i++) begin
            run(OP_CLAIM, i[2:0], 1'b1);
            check({7'h0, own_o[i]}, 8'h00);
            run(OP_RELEASE, i[2:0], 1'b0);
            run(OP_POLL, i[2:0], 1'b0);
        end
    endtask
    task automatic t_pass_on;
        far(3'h2, 1'b0);
        run(OP_CLAIM, 3'h2, 1'b0);
        run(OP_POLL, 3'h2, 1'b0);
        far(3'h2, 1'b1);
        run(OP_POLL, 3'h2, 1'b1);
        run(OP_RELEASE, 3'h2, 1'b0);
    endtask
    task automatic t_withdraw;
        far(3'h5, 1'b0);
        run(OP_CLAIM, 3'h5, 1'b0);
        run(OP_WITHDRAW, 3'h5, 1'b0);
        check({7'h0, own_o[5]}, 8'h01);
        far(3'h5, 1'b1);
        run(OP_POLL, 3'h5, 1'b0);
    endtask
    task automatic t_hold;
        run(OP_CLAIM, 3'h7, 1'b1);
        far(3'h7, 1'b0);
        run(OP_POLL, 3'h7, 1'b1);
        run(OP_RELEASE, 3'h7, 1'b0);
        check({7'h0, own_o[7]}, 8'h01);
        far(3'h7, 1'b1);
    endtask
    task automatic t_rerun;
        run(OP_CLAIM, 3'h4, 1'b1);
        do_reset();
        run(OP_POLL, 3'h4, 1'b0);
    endtask
    initial begin
        #40000;
        fail_count++;
        give_verdict();
    end
    initial begin
        do_reset();
        t_all_flags();
        t_pass_on();
        t_withdraw();
        t_hold();
        t_rerun();
        give_verdict();
    end
endmodule
